// >>> odf_pkg.sv
package odf_pkg;
  // timing at 20 MHz
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned FAULT_HOLD_MS = 200;
  localparam int unsigned SLOW_EXIT_MS  = 20;
  localparam int unsigned WD_LONG_MS    = 900;
  localparam int unsigned WD_MID_MS     = 450;
  localparam int unsigned WD_SHORT_MS   = 150;
  localparam int unsigned FAULT_HOLD_CYC = CLK_HZ / 1000 * FAULT_HOLD_MS;
  localparam int unsigned SLOW_EXIT_CYC  = CLK_HZ / 1000 * SLOW_EXIT_MS;
  localparam int unsigned WD_LONG_CYC    = CLK_HZ / 1000 * WD_LONG_MS;
  localparam int unsigned WD_MID_CYC     = CLK_HZ / 1000 * WD_MID_MS;
  localparam int unsigned WD_SHORT_CYC   = CLK_HZ / 1000 * WD_SHORT_MS;
  localparam int unsigned OL_DEB_CYC     = 2000;
  localparam int unsigned LED_ROW_CYC    = 5000;
  // register 3 field positions
  localparam int unsigned R3_PAIR_LO_BIT = 0;
  localparam int unsigned R3_PAIR_HI_BIT = 1;
  localparam int unsigned R3_WD_LSB      = 2;
  localparam logic [7:0]  R3_RESET       = 8'h00;
  localparam logic [1:0]  WD_SEL_MID     = 2'h1;
  localparam logic [1:0]  WD_SEL_SHORT   = 2'h2;

  typedef struct packed {
    logic       cs_b;
    logic       wd_en;
    logic       serial_sel;
    logic       out_en;
  } odf_sync_t;

  typedef struct packed {
    logic [2:0]  cs_sh;
    logic [2:0]  wd_en_sh;
    logic [2:0]  sel_sh;
    logic [2:0]  en_sh;
    logic [7:0]  reg3;
    logic [24:0] wd_cnt;
    logic        wd_fault;
    logic [7:0][12:0] deb_cnt;
    logic [7:0]  in_last;
    logic [7:0]  ol_last;
    logic [7:0]  ol_flag;
    logic [7:0][22:0] hold_cnt;
    logic [7:0]  slow;
    logic [7:0][18:0] slow_cnt;
    logic [12:0] row_cnt;
    logic [1:0]  row;
    logic [7:0]  out_on;
    logic        out_tri;
    logic [7:0]  pp_en;
    logic [7:0]  fault_bits;
    logic        fault_b;
    logic        wd_fault_b;
    logic        uv_b;
    logic [2:0]  uv_stat;
    logic [3:0]  led_row;
    logic [3:0]  led_col;
    logic [7:0]  ol_src_en;
  } odf_state_t;
endpackage

// >>> odf_core.sv
`timescale 1ns/1ps
`default_nettype none
module odf_core
(
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       cs_b_i,
  input  wire logic       watchdog_enable_input_i,
  input  wire logic       serial_parallel_select_i,
  input  wire logic       out_enable_i,
  input  wire logic       serial_only_variant_i,
  input  wire logic [7:0] chan_in_i,
  input  wire logic [7:0] serial_set_i,
  input  wire logic       reg3_wr_i,
  input  wire logic [7:0] reg3_data_i,
  input  wire logic [7:0] ol_chan_enable_i,
  input  wire logic       global_open_load_enable_i,
  input  wire logic       push_pull_select_i,
  input  wire logic [7:0] serial_pp_i,
  input  wire logic [7:0] open_load_raw_i,
  input  wire logic [7:0] driver_overtemp_i,
  input  wire logic       chip_overtemp_i,
  input  wire logic [7:0] short_detect_i,
  input  wire logic       logic_uv_i,
  input  wire logic       main_uv_i,
  input  wire logic       v5_uv_i,
  output logic [7:0]      out_on_o,
  output logic            out_tristate_o,
  output logic [7:0]      push_pull_en_o,
  output logic [7:0]      slow_mode_o,
  output logic [7:0]      fault_bits_o,
  output logic [7:0]      reg3_o,
  output logic            fault_b_o,
  output logic            watchdog_fault_output_o,
  output logic            uv_b_o,
  output logic [2:0]      uv_status_o,
  output logic [7:0]      ol_source_en_o,
  output logic [3:0]      led_row_o,
  output logic [3:0]      led_col_o
);
  odf_pkg::odf_state_t s_reg;
  odf_pkg::odf_state_t s_next;

  // stable when the second and third stages agree
  function automatic logic settled(input logic [2:0] sh, input logic prev);
    settled = (sh[1] == sh[2]) ? sh[2] : prev;
  endfunction

  function automatic logic [24:0] wd_limit(input logic [1:0] sel);
    if (sel == odf_pkg::WD_SEL_MID)
      wd_limit = 25'(odf_pkg::WD_MID_CYC);
    else if (sel == odf_pkg::WD_SEL_SHORT)
      wd_limit = 25'(odf_pkg::WD_SHORT_CYC);
    else
      wd_limit = 25'(odf_pkg::WD_LONG_CYC);
  endfunction

  odf_pkg::odf_sync_t sy;
  logic [7:0] eff_in;
  logic [7:0] hs_mode;
  logic [7:0] ol_en;
  logic [7:0] ol_det;
  logic [7:0] fault_lit;
  logic [7:0] level_lit;
  logic       cs_fall;
  logic       wd_active;
  logic       any_uv;
  logic       en_ok;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.cs_sh    = {s_reg.cs_sh[1:0], cs_b_i};
    s_next.wd_en_sh = {s_reg.wd_en_sh[1:0], watchdog_enable_input_i};
    s_next.sel_sh   = {s_reg.sel_sh[1:0], serial_parallel_select_i};
    s_next.en_sh    = {s_reg.en_sh[1:0], out_enable_i};
    sy.cs_b       = settled(s_reg.cs_sh, s_reg.cs_sh[2]);
    sy.wd_en      = settled(s_reg.wd_en_sh, s_reg.wd_en_sh[2]);
    sy.serial_sel = settled(s_reg.sel_sh, s_reg.sel_sh[2]);
    sy.out_en     = settled(s_reg.en_sh, s_reg.en_sh[2]);
    // fall seen as the low level moves into the third stage
    cs_fall = s_reg.cs_sh[2] && !s_reg.cs_sh[1];
    en_ok   = sy.out_en;
    any_uv  = logic_uv_i || main_uv_i || v5_uv_i;

    if (reg3_wr_i && !(serial_only_variant_i && !sy.serial_sel))
      s_next.reg3 = reg3_data_i;

    eff_in = sy.serial_sel ? serial_set_i : chan_in_i;
    if (s_reg.reg3[odf_pkg::R3_PAIR_LO_BIT])
    begin
      eff_in[1] = eff_in[0];
      eff_in[3] = eff_in[2];
    end
    if (s_reg.reg3[odf_pkg::R3_PAIR_HI_BIT])
    begin
      eff_in[5] = eff_in[4];
      eff_in[7] = eff_in[6];
    end
    s_next.pp_en = push_pull_select_i ? 8'hFF : serial_pp_i;
    if (s_reg.reg3[odf_pkg::R3_PAIR_LO_BIT])
      s_next.pp_en[3:0] = 4'h0;
    if (s_reg.reg3[odf_pkg::R3_PAIR_HI_BIT])
      s_next.pp_en[7:4] = 4'h0;
    hs_mode = ~s_next.pp_en;

    wd_active = sy.serial_sel && sy.wd_en;
    if (!wd_active || cs_fall)
    begin
      s_next.wd_cnt   = 25'h0;
      s_next.wd_fault = 1'b0;
    end
    else if (s_reg.wd_cnt >= wd_limit(s_reg.reg3[odf_pkg::R3_WD_LSB +: 2]) - 25'h1)
      s_next.wd_fault = 1'b1;
    else
      s_next.wd_cnt = s_reg.wd_cnt + 25'h1;

    // open-load detect with debounce, per channel
    ol_en = (ol_chan_enable_i | {8{global_open_load_enable_i && sy.serial_sel}})
            & hs_mode & {8{!any_uv}};
    ol_det = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      s_next.in_last[i] = eff_in[i];
      s_next.ol_last[i] = open_load_raw_i[i];
      if (eff_in[i] != s_reg.in_last[i] || open_load_raw_i[i] != s_reg.ol_last[i]
          || !ol_en[i])
        s_next.deb_cnt[i] = 13'h0;
      else if (s_reg.deb_cnt[i] < 13'(odf_pkg::OL_DEB_CYC))
        s_next.deb_cnt[i] = s_reg.deb_cnt[i] + 13'h1;
      ol_det[i] = ol_en[i] && open_load_raw_i[i]
                  && s_reg.deb_cnt[i] >= 13'(odf_pkg::OL_DEB_CYC);
      s_next.ol_flag[i] = ol_det[i];

      if (ol_det[i] || driver_overtemp_i[i])
        s_next.hold_cnt[i] = 23'(odf_pkg::FAULT_HOLD_CYC);
      else if (s_reg.hold_cnt[i] != 23'h0)
        s_next.hold_cnt[i] = s_reg.hold_cnt[i] - 23'h1;

      // slow mode exit after input low long enough
      if (short_detect_i[i])
      begin
        s_next.slow[i]     = 1'b1;
        s_next.slow_cnt[i] = 19'h0;
      end
      else if (s_reg.slow[i])
      begin
        if (eff_in[i])
          s_next.slow_cnt[i] = 19'h0;
        else if (s_reg.slow_cnt[i] >= 19'(odf_pkg::SLOW_EXIT_CYC - 1))
          s_next.slow[i] = 1'b0;
        else
          s_next.slow_cnt[i] = s_reg.slow_cnt[i] + 19'h1;
      end
    end

    for (int i = 0; i < 8; i++)
      s_next.fault_bits[i] = ol_det[i] || driver_overtemp_i[i] || s_next.hold_cnt[i] != 23'h0;
    fault_lit = s_next.fault_bits;

    s_next.out_on = eff_in & ~driver_overtemp_i & {8{!chip_overtemp_i}}
                    & {8{!s_next.wd_fault}} & {8{en_ok}};
    s_next.out_tri   = any_uv || !en_ok;
    s_next.ol_src_en = any_uv ? 8'h00 : ol_en;
    if (any_uv)
      s_next.out_on = 8'h00;

    s_next.fault_b    = !((|fault_lit) || chip_overtemp_i);
    s_next.wd_fault_b = !s_next.wd_fault;
    s_next.uv_stat = {v5_uv_i, main_uv_i, logic_uv_i};
    s_next.uv_b    = !main_uv_i;

    // matrix scan, one row at a time for 25% duty
    level_lit = s_next.out_on & ~fault_lit;
    if (s_reg.row_cnt >= 13'(odf_pkg::LED_ROW_CYC - 1))
    begin
      s_next.row_cnt = 13'h0;
      s_next.row     = s_reg.row + 2'h1;
    end
    else
      s_next.row_cnt = s_reg.row_cnt + 13'h1;
    s_next.led_row = en_ok ? (4'h1 << s_next.row) : 4'h0;
    case (s_next.row)
      2'h0: s_next.led_col = level_lit[3:0];
      2'h1: s_next.led_col = level_lit[7:4];
      2'h2: s_next.led_col = fault_lit[3:0];
      default: s_next.led_col = fault_lit[7:4];
    endcase
    if (!en_ok)
      s_next.led_col = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; constants only under reset
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_reg            <= '0;
      s_reg.reg3       <= odf_pkg::R3_RESET;
      s_reg.cs_sh      <= 3'h7;
      s_reg.fault_b    <= 1'b1;
      s_reg.wd_fault_b <= 1'b1;
      s_reg.uv_b       <= 1'b1;
      s_reg.out_tri    <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign out_on_o                = s_reg.out_on;
  assign out_tristate_o          = s_reg.out_tri;
  assign push_pull_en_o          = s_reg.pp_en;
  assign slow_mode_o             = s_reg.slow;
  assign fault_bits_o            = s_reg.fault_bits;
  assign reg3_o                  = s_reg.reg3;
  assign fault_b_o               = s_reg.fault_b;
  assign watchdog_fault_output_o = s_reg.wd_fault_b;
  assign uv_b_o                  = s_reg.uv_b;
  assign uv_status_o             = s_reg.uv_stat;
  assign ol_source_en_o          = s_reg.ol_src_en;
  assign led_row_o               = s_reg.led_row;
  assign led_col_o               = s_reg.led_col;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_fault_seen;
    s_next.fault_bits != 8'h00;
  endsequence
  property p_fault_global;
    @(posedge clock_i) disable iff (!rst_b_i) s_fault_seen |=> !fault_b_o;
  endproperty
  a_fault_global: assert property (p_fault_global) else $error("fault not global");
  property p_chip_hot;
    @(posedge clock_i) disable iff (!rst_b_i) chip_overtemp_i |=> out_on_o == 8'h00 && !fault_b_o;
  endproperty
  a_chip_hot: assert property (p_chip_hot) else $error("chip overtemp ignored");
  property p_drv_hot;
    @(posedge clock_i) disable iff (!rst_b_i)
      driver_overtemp_i != 8'h00 |=> (out_on_o & $past(driver_overtemp_i)) == 8'h00
        && (fault_bits_o & $past(driver_overtemp_i)) == $past(driver_overtemp_i);
  endproperty
  a_drv_hot: assert property (p_drv_hot) else $error("driver overtemp ignored");
  property p_uv_off;
    @(posedge clock_i) disable iff (!rst_b_i)
      any_uv |=> out_tristate_o && ol_source_en_o == 8'h00;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("lockout failed");
  property p_uv_pin;
    @(posedge clock_i) disable iff (!rst_b_i) 1'b1 |=> uv_b_o == !$past(main_uv_i);
  endproperty
  a_uv_pin: assert property (p_uv_pin) else $error("uv pin wrong");
  property p_pair_pp;
    @(posedge clock_i) disable iff (!rst_b_i)
      reg3_o[odf_pkg::R3_PAIR_LO_BIT] |=> push_pull_en_o[3:0] == 4'h0;
  endproperty
  a_pair_pp: assert property (p_pair_pp) else $error("pairing left push-pull");
  property p_pair_hi;
    @(posedge clock_i) disable iff (!rst_b_i)
      reg3_o[odf_pkg::R3_PAIR_HI_BIT] |=> push_pull_en_o[7:4] == 4'h0;
  endproperty
  a_pair_hi: assert property (p_pair_hi) else $error("upper pairing left push-pull");
  property p_led_excl;
    @(posedge clock_i) disable iff (!rst_b_i) $onehot0(led_row_o);
  endproperty
  a_led_excl: assert property (p_led_excl) else $error("two rows lit");
  property p_en_low;
    @(posedge clock_i) disable iff (!rst_b_i)
      !sy.out_en |=> out_on_o == 8'h00 && led_col_o == 4'h0;
  endproperty
  a_en_low: assert property (p_en_low) else $error("enable low ignored");
  property p_wd_idle;
    @(posedge clock_i) disable iff (!rst_b_i) !wd_active |=> watchdog_fault_output_o;
  endproperty
  a_wd_idle: assert property (p_wd_idle) else $error("watchdog tripped while off");
  property p_wd_restart;
    @(posedge clock_i) disable iff (!rst_b_i)
      wd_active && cs_fall |=> s_reg.wd_cnt == 25'h0 && watchdog_fault_output_o;
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted");
  property p_wd_trip;
    @(posedge clock_i) disable iff (!rst_b_i)
      s_next.wd_fault |=> out_on_o == 8'h00 && !watchdog_fault_output_o;
  endproperty
  a_wd_trip: assert property (p_wd_trip) else $error("watchdog timeout ignored");
endmodule
`default_nettype wire

// >>> odf_load_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// load bank: an open wire shows on the comparator only while the
// off-state source pulls it up or the switch is closed into it
module odf_load_model
(
  input  wire logic [7:0] out_on_i,
  input  wire logic [7:0] src_en_i,
  input  wire logic [7:0] open_mask_i,
  output logic [7:0]      ol_raw_o
);
  // a healthy wire never trips, so no reading without excitation
  assign ol_raw_o = open_mask_i & (src_en_i | out_on_i);
endmodule
`default_nettype wire

// >>> test_octal_driver_fault_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_octal_driver_fault_control;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cs_b = 1'b1, wd_en = 1'b0, sel = 1'b0, oe = 1'b1, sonly = 1'b0;
  logic        wr = 1'b0, gol = 1'b0, pps = 1'b0, cot = 1'b0;
  logic [2:0]  uvv = 3'h0;
  logic [7:0]  cin = 8'h00, sset = 8'h00, d3 = 8'h00, olen = 8'h00, spp = 8'h00;
  logic [7:0]  dot = 8'h00, sh = 8'h00, omask = 8'h00, olraw;
  logic [7:0]  on, ppen, slow, fbits, r3, olsrc;
  logic        tri_o, fb, wdf, uvb;
  logic [2:0]  uvs;
  logic [3:0]  lrow, lcol;
  logic [31:0] seed = 32'h00006875, cnt [4];
  int          num_errors = 0, compares = 0, cyc = 0;
  always #25 clock_i = ~clock_i;
  odf_core i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b),
    .watchdog_enable_input_i(wd_en), .serial_parallel_select_i(sel),
    .out_enable_i(oe), .serial_only_variant_i(sonly), .chan_in_i(cin),
    .serial_set_i(sset), .reg3_wr_i(wr), .reg3_data_i(d3), .ol_chan_enable_i(olen),
    .global_open_load_enable_i(gol), .push_pull_select_i(pps), .serial_pp_i(spp),
    .open_load_raw_i(olraw), .driver_overtemp_i(dot), .chip_overtemp_i(cot),
    .short_detect_i(sh), .logic_uv_i(uvv[0]), .main_uv_i(uvv[1]), .v5_uv_i(uvv[2]),
    .out_on_o(on), .out_tristate_o(tri_o), .push_pull_en_o(ppen), .slow_mode_o(slow),
    .fault_bits_o(fbits), .reg3_o(r3), .fault_b_o(fb), .watchdog_fault_output_o(wdf),
    .uv_b_o(uvb), .uv_status_o(uvs), .ol_source_en_o(olsrc), .led_row_o(lrow),
    .led_col_o(lcol));
  odf_load_model i_load (.out_on_i(on), .src_en_i(olsrc), .open_mask_i(omask),
    .ol_raw_o(olraw));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // one-cycle write strobe, then let the register settle
  task automatic wr3(input logic [7:0] v);
    @(posedge clock_i);
    wr <= 1'b1;
    d3 <= v;
    @(posedge clock_i);
    wr <= 1'b0;
    step(2);
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // paired channels copy the even input; the odd input is ignored
  function automatic logic [7:0] pair_out(input logic [7:0] i, input logic [1:0] m);
    pair_out = i;
    if (m[0])
      pair_out[3:0] = {i[2], i[2], i[0], i[0]};
    if (m[1])
      pair_out[7:4] = {i[6], i[6], i[4], i[4]};
  endfunction
  // hang guard sized well above the whole sequence
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    step(20);
    rst_b_i <= 1'b1;
    step(6);
    check(r3, 8'h00);
    check({fb, wdf, tri_o}, 3'h6);
    // every pairing mode with random inputs, push-pull requested
    pps <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr3(8'(m));
      check(r3, 8'(m));
      for (int k = 0; k < 4; k++)
      begin
        cin <= 8'(rnd());
        step(6);
        check(on, pair_out(cin, 2'(m)));
        check(ppen, {m[1] ? 4'h0 : 4'hF, m[0] ? 4'h0 : 4'hF});
      end
    end
    // refused write in parallel mode, accepted in serial mode
    sonly <= 1'b1;
    wr3(8'h0C);
    check(r3, 8'h03);
    sel <= 1'b1;
    sset <= 8'hA5;
    // host enables and feeds the watchdog
    wd_en <= 1'b1;
    step(6);
    wr3(8'h04);
    check(r3, 8'h04);
    check(on, 8'hA5);
    cs_b <= 1'b0;
    step(4);
    cs_b <= 1'b1;
    step(4);
    check(wdf, 1'b1);
    // global open-load enable counts only in serial mode
    pps <= 1'b0;
    gol <= 1'b1;
    step(6);
    check(olsrc, 8'hFF);
    sel <= 1'b0;
    sonly <= 1'b0;
    pps <= 1'b0;
    cin <= 8'hFF;
    oe <= 1'b0;
    step(6);
    check({on, lcol}, 12'h000);
    oe <= 1'b1;
    step(6);
    check({on, tri_o}, 9'h1FE);
    // each supply alone drops below its lockout
    for (int k = 0; k < 3; k++)
    begin
      uvv <= 3'(1 << k);
      step(6);
      check({tri_o, olsrc, uvs}, {1'b1, 8'h00, 3'(1 << k)});
      check(uvb, 1'(k != 1));
      uvv <= 3'h0;
      step(6);
    end
    // rows one-hot, each a quarter of a full scan
    for (int r = 0; r < 4; r++)
      cnt[r] = 0;
    repeat (20000)
    begin
      @(posedge clock_i);
      for (int r = 0; r < 4; r++)
        cnt[r] += 32'(lrow[r]);
      if (!$onehot(lrow))
        check(lrow, 4'h1);
    end
    for (int r = 0; r < 4; r++)
      check(cnt[r], 32'h00001388);
    // open wire on channel 0 must outlast the debounce before showing
    olen <= 8'h03;
    spp <= 8'h02;
    omask <= 8'h01;
    step(1500);
    check(fbits[0], 1'b0);
    check({ppen, olsrc}, 16'h0201);
    step(1000);
    check({fbits, fb}, 9'h002);
    // level column dark and fault column lit for the faulty channel
    while (lrow != 4'h1)
      @(posedge clock_i);
    check(lcol, 4'hE);
    while (lrow != 4'h4)
      @(posedge clock_i);
    check(lcol, 4'h1);
    omask <= 8'h00;
    step(10);
    check(fb, 1'b0);
    dot <= 8'h20;
    step(6);
    check({on, fbits[5]}, 9'h1BF);
    dot <= 8'h00;
    step(6);
    check(on, 8'hFF);
    cot <= 1'b1;
    step(6);
    check({on, fb}, 9'h000);
    cot <= 1'b0;
    sh <= 8'h04;
    step(1);
    sh <= 8'h00;
    cin[2] <= 1'b0;
    step(1000);
    check(slow, 8'h04);
    report_and_stop();
  end
endmodule
`default_nettype wire
